// ### hdl/pimg_access.v
// Process image register access terminal with an Avalon-MM register port
//
// Register access over Avalon-MM and the register addresses were chosen for this implementation.
`timescale 1ns/10ps
`include "pimg_access_regs.vh"

module pimg_access (
	// Clock and reset
	input wire clock,
	input wire sys_rst,
	// Avalon-MM slave
	input wire [3:0] address,
	input wire read,
	input wire write,
	input wire [31:0] writedata,
	input wire [3:0] byteenable,
	output reg [31:0] readdata,
	output reg waitrequest,
	// Block state
	output reg write_enabled_reg,
	output reg [7:0] status_byte_reg,
	output reg [15:0] input_data_word_reg
);

	// Bus handshake states, one-hot
	localparam [1:0] ST_IDLE = 2'b01;
	localparam [1:0] ST_ACK = 2'b10;

	// Kinds of answer in the input image, one-hot
	localparam [2:0] ANS_OFF = 3'b001;
	localparam [2:0] ANS_READ = 3'b010;
	localparam [2:0] ANS_WRITE = 3'b100;

	// Protection states, one-hot
	localparam [1:0] PROT_LOCKED = 2'b01;
	localparam [1:0] PROT_OPEN = 2'b10;

	// Writable: code word always, user registers only when unlocked
	function reg_writable;
		input [5:0] num;
		input code_open;
		begin
			reg_writable = (num == `REG_CODE_WORD) ||
				((num >= `REG_FIRST_USER) && code_open);
		end
	endfunction

	// Reset value of a bank entry
	function [15:0] reg_reset_value;
		input [5:0] num;
		begin
			if (num == `REG_FEATURE) begin
				reg_reset_value = `FEATURE_RESET;
			end else begin
				reg_reset_value = `BANK_RESET;
			end
		end
	endfunction

	// Kind of answer a control byte asks for
	function [2:0] answer_kind;
		input [7:0] ctrl;
		begin
			if (!ctrl[`CTRL_ACCESS_BIT]) begin
				answer_kind = ANS_OFF;
			end else if (ctrl[`CTRL_WRITE_BIT]) begin
				answer_kind = ANS_WRITE;
			end else begin
				answer_kind = ANS_READ;
			end
		end
	endfunction

	// Image word on the bus: head byte in byte 0, data high in byte 1, low in byte 2
	function [31:0] pack_image;
		input [7:0] head;
		input [15:0] word;
		begin
			pack_image = 32'h00000000;
			pack_image[`IMG_BYTE0_LSB +: 8] = head;
			pack_image[`IMG_BYTE1_LSB +: 8] = word[15:8];
			pack_image[`IMG_BYTE2_LSB +: 8] = word[7:0];
		end
	endfunction

	// Code word test, any value but the unlock code locks
	function code_opens;
		input [15:0] word;
		begin
			code_opens = (word == `CODE_UNLOCK);
		end
	endfunction

	// Output image held for the controller
	reg [7:0] control_byte_reg;
	reg [7:0] control_byte_next;
	reg [15:0] output_data_word_reg;
	reg [15:0] output_data_word_next;

	// Input image next values
	reg [7:0] status_byte_next;
	reg [15:0] input_data_word_next;

	// Handshake, protection and read data state
	reg [1:0] state_reg;
	reg [1:0] state_next;
	reg [1:0] prot_reg;
	reg [1:0] prot_next;
	reg [31:0] readdata_next;

	// Byte lane strobes of the output image
	wire [2:0] lane_we;

	// Register bank and control decode
	wire [15:0] bank_word [0:`BANK_DEPTH-1];
	wire [`BANK_DEPTH-1:0] bank_we;
	wire [2:0] answer_now;
	wire [5:0] reg_num;
	wire [15:0] addressed_value;
	wire unlocked;
	wire bus_take;
	wire bus_commit;
	wire image_write;
	genvar g;

	// Control byte decode
	assign answer_now = answer_kind(control_byte_reg);
	assign reg_num = control_byte_reg[`CTRL_REGNUM_MSB:0];
	assign addressed_value = bank_word[reg_num];
	assign unlocked = code_opens(bank_word[`REG_CODE_WORD]);

	// Bus handshake: the idle state takes a request, the ack state completes it
	// Read data is latched on taking, a write lands only when completed
	assign bus_take = (read | write) & state_reg[0];
	assign bus_commit = state_reg[1];
	assign image_write = bus_commit & write & (address == `OFS_OUT_IMAGE);

	// Next handshake state; the ack state lasts exactly one cycle
	always @* begin
		state_next = ST_IDLE;
		case (state_reg)
			ST_IDLE: begin
				if (read | write) begin
					state_next = ST_ACK;
				end else begin
					state_next = ST_IDLE;
				end
			end
			ST_ACK: begin
				state_next = ST_IDLE;
			end
			default: begin
				state_next = ST_IDLE;
			end
		endcase
	end

	// Handshake state and waitrequest, low only in the ack state
	always @(posedge clock) begin
		if (sys_rst) begin
			state_reg <= ST_IDLE;
			waitrequest <= 1'b1;
		end else begin
			state_reg <= state_next;
			waitrequest <= ~state_next[1];
		end
	end

	// Read data mux, unmapped offsets read zero
	always @* begin
		readdata_next = 32'h00000000;
		case (address)
			`OFS_OUT_IMAGE: begin
				readdata_next = pack_image(control_byte_reg, output_data_word_reg);
			end
			`OFS_IN_IMAGE: begin
				readdata_next = pack_image(status_byte_reg, input_data_word_reg);
			end
			`OFS_PROT_STATE: begin
				readdata_next[0] = write_enabled_reg;
			end
			default: begin
				readdata_next = 32'h00000000;
			end
		endcase
	end

	// Read data is captured when the request is taken
	// Held until the next read, so the master may sample it at completion
	always @(posedge clock) begin
		if (sys_rst) begin
			readdata <= 32'h00000000;
		end else if (bus_take && read) begin
			readdata <= readdata_next;
		end
	end

	// Output image lane strobes, one per byte lane
	generate
		for (g = 0; g < 3; g = g + 1) begin : lane_strobe
			assign lane_we[g] = image_write & byteenable[g];
		end
	endgenerate

	// Output image next value, byte lanes honoured
	// Writes to the input image or the protection word are dropped
	always @* begin
		control_byte_next = control_byte_reg;
		output_data_word_next = output_data_word_reg;
		if (lane_we[0]) begin
			control_byte_next = writedata[`IMG_BYTE0_LSB +: 8];
		end
		if (lane_we[1]) begin
			output_data_word_next[15:8] = writedata[`IMG_BYTE1_LSB +: 8];
		end
		if (lane_we[2]) begin
			output_data_word_next[7:0] = writedata[`IMG_BYTE2_LSB +: 8];
		end
	end

	// Output image registers
	always @(posedge clock) begin
		if (sys_rst) begin
			control_byte_reg <= `CTRL_RESET;
			output_data_word_reg <= `DATA_RESET;
		end else begin
			control_byte_reg <= control_byte_next;
			output_data_word_reg <= output_data_word_next;
		end
	end

	// Register bank, one entry per index; restart clears the code word and relocks
	// Registers below the code word are never written and read as zero
	// A posted write repeats every cycle, which leaves the same value
	generate
		for (g = 0; g < `BANK_DEPTH; g = g + 1) begin : bank_entry
			localparam [5:0] IDX = g;
			reg [15:0] entry_reg;
			// Entry write strobe
			assign bank_we[g] = (answer_now == ANS_WRITE) && (reg_num == IDX) &&
				reg_writable(IDX, unlocked);
			// Entry storage
			always @(posedge clock) begin
				if (sys_rst) begin
					entry_reg <= reg_reset_value(IDX);
				end else if (bank_we[g]) begin
					entry_reg <= output_data_word_reg;
				end
			end
			assign bank_word[g] = entry_reg;
		end
	endgenerate

	// Answer in the input image, refreshed every cycle
	// The word after a write ack is forced to zero, it carries nothing
	always @* begin
		status_byte_next = `CTRL_RESET;
		input_data_word_next = `DATA_RESET;
		case (answer_now)
			ANS_READ: begin
				status_byte_next = control_byte_reg;
				input_data_word_next = addressed_value;
			end
			ANS_WRITE: begin
				status_byte_next = control_byte_reg & `CTRL_WRITE_MASK;
				input_data_word_next = `DATA_RESET;
			end
			ANS_OFF: begin
				status_byte_next = `CTRL_RESET;
				input_data_word_next = `DATA_RESET;
			end
			default: begin
				status_byte_next = `CTRL_RESET;
				input_data_word_next = `DATA_RESET;
			end
		endcase
	end

	// Input image registers
	always @(posedge clock) begin
		if (sys_rst) begin
			status_byte_reg <= `CTRL_RESET;
			input_data_word_reg <= `DATA_RESET;
		end else begin
			status_byte_reg <= status_byte_next;
			input_data_word_reg <= input_data_word_next;
		end
	end

	// Next protection state, follows the stored code word
	always @* begin
		prot_next = PROT_LOCKED;
		case (prot_reg)
			PROT_LOCKED: begin
				if (unlocked) begin
					prot_next = PROT_OPEN;
				end else begin
					prot_next = PROT_LOCKED;
				end
			end
			PROT_OPEN: begin
				if (unlocked) begin
					prot_next = PROT_OPEN;
				end else begin
					prot_next = PROT_LOCKED;
				end
			end
			default: begin
				prot_next = PROT_LOCKED;
			end
		endcase
	end

	// Protection state seen by software; restart locks
	// Lags the code word by one cycle
	always @(posedge clock) begin
		if (sys_rst) begin
			prot_reg <= PROT_LOCKED;
			write_enabled_reg <= 1'b0;
		end else begin
			prot_reg <= prot_next;
			write_enabled_reg <= prot_next[1];
		end
	end

endmodule

// ### hdl/pimg_access_regs.vh
// Offsets, field positions, codes and reset values of the process image register access block
`ifndef PIMG_ACCESS_REGS_VH
`define PIMG_ACCESS_REGS_VH

// Avalon byte offsets of the bus-side registers
`define OFS_OUT_IMAGE 4'h0
`define OFS_IN_IMAGE 4'h4
`define OFS_PROT_STATE 4'h8

// Process image byte lanes inside a 32-bit bus word
`define IMG_BYTE0_LSB 0
`define IMG_BYTE1_LSB 8
`define IMG_BYTE2_LSB 16

// Control and status byte fields
`define CTRL_ACCESS_BIT 7
`define CTRL_WRITE_BIT 6
`define CTRL_REGNUM_MSB 5
`define CTRL_WRITE_MASK 8'hBF

// Register bank layout
`define BANK_DEPTH 64
`define REG_CODE_WORD 6'h1F
`define REG_FIRST_USER 6'h20
`define REG_FEATURE 6'h20

// Code word values and reset values
`define CODE_UNLOCK 16'h1235
`define CODE_RESET 16'h0000
`define FEATURE_RESET 16'h0004
`define BANK_RESET 16'h0000
`define CTRL_RESET 8'h00
`define DATA_RESET 16'h0000

`endif

// ### bench/pimg_access_sva.sv
// Checker for the process image register access block
`timescale 1ns/10ps
module pimg_access_sva (
	// Bus
	input wire clock, input wire sys_rst, input wire [3:0] address,
	input wire read, input wire write, input wire [31:0] readdata, input wire waitrequest,
	// Image
	input wire write_enabled_reg, input wire [7:0] status_byte_reg,
	input wire [15:0] input_data_word_reg
);
	default clocking @(posedge clock); endclocking
	default disable iff (sys_rst);
	// Handshake and read paths
	a_wait_pulse: assert property (!waitrequest |=> waitrequest) else $error("wait");
	a_wait_answer: assert property ((read || write) && waitrequest |=> !waitrequest)
		else $error("answer");
	a_hole_zero: assert property (read && waitrequest && address == 4'hC |=> readdata == 0)
		else $error("hole");
	a_status_read: assert property (read && waitrequest && address == 4'h4 |=>
		readdata[7:0] == $past(status_byte_reg)) else $error("status");
	// Image answers
	a_ack_bit6: assert property (!status_byte_reg[6]) else $error("bit6");
	a_off_quiet: assert property (!status_byte_reg[7] |-> !input_data_word_reg)
		else $error("off");
	a_status_cause: assert property ($changed(status_byte_reg) |-> $past(write, 2))
		else $error("cause");
	a_lock_cause: assert property ($changed(write_enabled_reg) |-> $past(write, 3))
		else $error("lock");
	c_unlock: cover property ($rose(write_enabled_reg));
	c_relock: cover property ($fell(write_enabled_reg));
	c_wack: cover property (status_byte_reg == 8'h9F);
endmodule
bind pimg_access pimg_access_sva u_sva (.*);

// ### bench/ctl_master.sv
// Controller model driving the Avalon-MM port
`timescale 1ns/10ps
module ctl_master (
	// Bus
	input wire clock, input wire [31:0] readdata, input wire waitrequest,
	output logic [3:0] address, output logic read, output logic write,
	output logic [31:0] writedata, output logic [3:0] byteenable
);
	initial {address, read, write, writedata, byteenable} = '0;
	// One transfer held until waitrequest is sampled low
	task automatic xfer(input bit wr, input logic [3:0] a, input logic [31:0] wd,
		output logic [31:0] rd, output bit ok);
		int n;
		n = 0;
		@(posedge clock);
		address <= a;
		writedata <= wd;
		byteenable <= 4'h7;
		read <= !wr;
		write <= wr;
		do begin
			@(posedge clock);
			n++;
		end while (waitrequest !== 1'b0 && n < 50);
		rd = readdata;
		ok = n < 50;
		read <= 1'b0;
		write <= 1'b0;
		writedata <= ~wd; // Released lines show no stale value
	endtask
endmodule

// ### bench/pimg_access_tb.sv
// Testbench for the process image register access block
`timescale 1ns/10ps
module pimg_access_tb;
	logic clock = 1'b0, sys_rst = 1'b1, read, write, waitrequest, write_enabled_reg;
	logic [3:0] address, byteenable;
	logic [31:0] writedata, readdata, rd;
	logic [7:0] status_byte_reg;
	logic [15:0] input_data_word_reg;
	bit ok;
	int err_total = 0, n_tests = 0;
	initial forever #2.5 clock = ~clock;
	pimg_access u_dut (.*);
	ctl_master u_ctl (.*);
	task automatic conclude();
		$display("checks %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	// Transfer that ends the run on a hang
	task automatic bus(bit wr, logic [3:0] a, logic [31:0] wd);
		u_ctl.xfer(wr, a, wd, rd, ok);
		if (!ok) begin
			err_total++;
			conclude();
		end
	endtask
	// Control byte and word out, status and input word back
	task automatic acc(string nm, logic [7:0] c, logic [15:0] w, logic [7:0] s, logic [15:0] d);
		bus(1, 4'h0, {8'h00, w[7:0], w[15:8], c});
		repeat (3) @(posedge clock);
		bus(0, 4'h4, 0);
		chk(nm, {8'h00, d[7:0], d[15:8], s}, rd);
	endtask
	task automatic t_restart();
		acc("r31", 8'h9F, 16'h0000, 8'h9F, 16'h0000);
		acc("r32", 8'hA0, 16'hFFFF, 8'hA0, 16'h0004);
		$display("restart done");
	endtask
	task automatic t_locked();
		acc("w32", 8'hE0, 16'h0002, 8'hA0, 16'h0000);
		acc("r32", 8'hA0, 16'h0000, 8'hA0, 16'h0004);
		$display("locked done");
	endtask
	task automatic t_unlock();
		acc("w31", 8'hDF, 16'h1235, 8'h9F, 16'h0000);
		bus(0, 4'h8, 0);
		chk("lock", 32'h1, rd);
		chk("enable", 32'h1, {31'h0, write_enabled_reg});
		acc("w32", 8'hE0, 16'h0002, 8'hA0, 16'h0000);
		acc("r32", 8'hA0, 16'h5A5A, 8'hA0, 16'h0002);
		$display("unlock done");
	endtask
	task automatic t_relock();
		acc("w31", 8'hDF, 16'h0000, 8'h9F, 16'h0000);
		chk("enable", 32'h0, {31'h0, write_enabled_reg});
		acc("w32", 8'hE0, 16'h0007, 8'hA0, 16'h0000);
		acc("r32", 8'hA0, 16'h0000, 8'hA0, 16'h0002);
		acc("off", 8'h1F, 16'h1235, 8'h00, 16'h0000);
		bus(0, 4'hC, 0);
		chk("hole", 32'h0, rd);
		$display("relock done");
	endtask
	initial begin
		repeat (4) @(posedge clock);
		sys_rst <= 1'b0;
		t_restart();
		t_locked();
		t_unlock();
		sys_rst <= 1'b1;
		repeat (2) @(posedge clock);
		sys_rst <= 1'b0;
		t_restart();
		t_unlock();
		t_relock();
		conclude();
	end
endmodule
